// file: rtl/lcd_drv_defs.vh
`ifndef LCD_DRV_DEFS_VH
`define LCD_DRV_DEFS_VH
// register addresses (byte index on the plain register port)
`define ADDR_MEM_LAST      5'h10
`define ADDR_CTRL          5'h11
`define ADDR_CFG           5'h12
`define ADDR_STATUS        5'h13
// control register fields
`define CTRL_CONTRAST_LSB  0
`define CTRL_CONTRAST_MSB  4
`define CTRL_GND_BIT       5
`define CTRL_DUTY_LSB      6
`define CTRL_DUTY_MSB      7
`define CTRL_CLKSEL_BIT    8
`define CTRL_FRM_LSB       9
`define CTRL_FRM_MSB       12
`define CTRL_RESET         13'h0000
// config register fields
`define CFG_DPE_BIT        0
`define CFG_OPM_BIT        1
`define CFG_PCF_LSB        4
`define CFG_PCF_MSB        7
`define CFG_RESET          8'h00
`define PCF_ALL_SEG        4'hf
// duty encodings
`define DUTY_STATIC        2'h0
`define DUTY_HALF          2'h1
`define DUTY_THIRD         2'h2
`define DUTY_QUARTER       2'h3
// controller clock ticks per frame per (divider+1)
`define TICKS_THIRD        8'h60
`define TICKS_OTHER        8'h40
// high-frequency clock predivider
`define HF_DIV             128
`endif

// file: rtl/segment_lcd_mux_driver.v
// Overview of operation
// - 1/3 large package: bits 0..2, 4..6
// - 1/4 large package: nibbles map segment pairs
// - waveforms generated continuously once configured
// - static mode uses common 0 all frame
// - half duty drives commons 0 and 1
// - third duty drives commons 0 to 2
// - quarter duty drives commons 0 to 3
// - memory bit one lights segment
// - clock select one picks fast clock/128
// - duty zero selects static drive
// - ground bit connects contrast resistor internally
// - pin function 0x0f makes all segment outputs
// - operation bit one enables waveform generation
// - frame equals clock/((div+1)*96 or 64)
// - fast clock source suspends during stop
// - unused memory stays ordinary storage
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/10ps
`include "lcd_drv_defs.vh"
module segment_lcd_mux_driver #(
    parameter SEG_COUNT = 34,   // segment outputs on large package
    parameter PIN_GROUPS = 4    // pin function groups
) (
    // clock and reset
    input  wire                 clock_in,
    input  wire                 rst_b_in,
    // clock source enables and power state
    input  wire                 clk_32k_tick_in,  // 32 kHz enable pulse
    input  wire                 hf_clk_tick_in,   // fast clock enable
    input  wire                 stop_mode_in,     // stop mode active
    input  wire                 hf_warm_in,       // fast clock warm
    // plain register port
    input  wire [4:0]           addr_in,
    input  wire [15:0]          wdata_in,
    input  wire                 wr_in,
    input  wire                 rd_in,
    output reg  [15:0]          rdata_out,
    // glass pins
    output reg  [SEG_COUNT-1:0] segment_output_out,
    output reg  [SEG_COUNT-1:0] segment_enable_out,
    output reg  [3:0]           backplane_output_out,
    output reg  [3:0]           backplane_enable_out,
    // contrast control for the analog pad cell
    output wire [4:0]           contrast_resistor_out,
    output wire                 resistor_ground_out,
    // one-cycle frame marker
    output wire                 frame_start_out
);
    // the block turns 17 bytes of display memory into segment
    // and common pin levels for a passive glass panel. software
    // writes memory and mode over the plain register port; the
    // waveform runs from either a 32 kHz enable or the fast
    // enable divided by 128. contrast resistor settings only
    // pass through to the analog pad cell outside this block.
    // limitation: analog drive levels are not modelled; the pins
    // here give only which level a pin takes, high or low
    // display memory, 17 bytes
    reg  [7:0]  mem_ff [0:16];
    reg  [12:0] ctrl_ff;          // control register
    reg  [7:0]  cfg_ff;           // config register
    reg  [6:0]  hf_div_ff;        // fast clock predivider
    reg  [7:0]  tick_ff;          // ticks inside one divider step
    reg  [3:0]  frm_cnt_ff;       // divider steps
    reg  [1:0]  phase_ff;         // active common phase
    reg         invert_ff;        // polarity half for ac drive
    reg         frame_pulse_ff;   // one-cycle frame marker
    wire [1:0]  duty;
    wire [3:0]  frame_divider_field;
    wire        run;
    wire        lcd_tick;
    wire        hf_tick;
    wire [7:0]  phase_len;
    wire [1:0]  last_phase;
    reg  [7:0]  nxt_tick;         // tick count after this lcd tick
    reg  [3:0]  nxt_frm_cnt;      // divider step after this lcd tick
    wire        pins_on;          // display enabled and running
    wire        hf_src_ok;        // fast source usable this cycle
    wire [SEG_COUNT-1:0] nxt_seg_level;   // segment pin levels
    wire [SEG_COUNT-1:0] nxt_seg_enable;  // segment pin drives
    wire [3:0]  nxt_com_level;    // common pin levels
    wire [3:0]  nxt_com_enable;   // common pin drives
    integer     i;                // memory reset loop only
    genvar      g;                // segment pin index
    genvar      k;                // common pin index

    assign duty = ctrl_ff[`CTRL_DUTY_MSB:`CTRL_DUTY_LSB];
    assign frame_divider_field  = ctrl_ff[`CTRL_FRM_MSB:`CTRL_FRM_LSB];
    assign resistor_ground_out = ctrl_ff[`CTRL_GND_BIT];
    assign contrast_resistor_out =
        ctrl_ff[`CTRL_CONTRAST_MSB:`CTRL_CONTRAST_LSB];
    assign frame_start_out = frame_pulse_ff;

    // number of commons less one for a duty code
    // used by the phase counter and by the common enables
    function [1:0] last_com;
        input [1:0] d;
        begin
            case (d)
                `DUTY_STATIC:  last_com = 2'h0;
                `DUTY_HALF:    last_com = 2'h1;
                `DUTY_THIRD:   last_com = 2'h2;
                default:       last_com = 2'h3;
            endcase
        end
    endfunction

    // tick count per phase so phases x count is 96 or 64
    // only the third duty stretches the frame to 96 ticks; the
    // other modes trade phase length against common count
    assign last_phase = last_com(duty);
    assign phase_len = (duty == `DUTY_THIRD) ? 8'h20 :
                       (duty == `DUTY_STATIC) ? `TICKS_OTHER :
                       (duty == `DUTY_HALF) ? 8'h20 : 8'h10;

    // fast tick passes only on the last predivider count
    function hf_tick_in_gate;
        input       t;
        input [6:0] c;
        begin
            hf_tick_in_gate = t & (c == 7'h7f);
        end
    endfunction

    // fast clock divided by 128 when selected
    // the predivider spans all 128 fast periods, so one tick
    // in 128 reaches the phase counters
    assign hf_tick = hf_tick_in_gate(hf_clk_tick_in, hf_div_ff);

    // fast source halts in stop until warmup done
    // while suspended the pins hold their last levels; keeping
    // the glass free of dc then is left to software
    assign hf_src_ok = ~stop_mode_in & hf_warm_in;
    assign lcd_tick = ctrl_ff[`CTRL_CLKSEL_BIT] ?
                      (hf_tick & hf_src_ok) :
                      clk_32k_tick_in;
    assign run = cfg_ff[`CFG_OPM_BIT];

    // predivider for the fast clock; frozen in stop
    // free running otherwise, so the first tick after a source
    // switch comes at most 128 fast periods late
    always @(posedge clock_in) begin
        if (!rst_b_in) begin
            hf_div_ff <= 7'h00;
        end else if (hf_clk_tick_in && !stop_mode_in) begin
            hf_div_ff <= hf_div_ff + 7'h01;
        end
    end

    // next tick and divider counts
    // tick wraps at phase_len - 1, divider step wraps at frm
    // pure next-state logic, no state of its own
    always @* begin
        nxt_tick = tick_ff;
        nxt_frm_cnt = frm_cnt_ff;
        if (tick_ff == phase_len - 8'h01) begin
            nxt_tick = 8'h00;
            if (frm_cnt_ff == frame_divider_field) begin
                nxt_frm_cnt = 4'h0;
            end else begin
                nxt_frm_cnt = frm_cnt_ff + 4'h1;
            end
        end else begin
            nxt_tick = tick_ff + 8'h01;
        end
    end

    // timing chain: every lcd tick advances tick_ff; a full run
    // of phase_len ticks advances frm_cnt_ff; frm + 1 such runs
    // make one common phase; last_phase + 1 phases make a frame.
    // so a frame is phase_len * (frm + 1) * commons lcd ticks:
    //   static 64 * 1, half 32 * 2, quarter 16 * 4 = 64
    //   third  32 * 3 = 96
    // a change of duty or divider takes effect on the next
    // compare, so the frame in progress may come out short;
    // software should set the mode with operation off
    // a phase count left above the new last phase wraps to
    // common 0 at the next step rather than hanging
    // equal-length phases, one per common per frame
    always @(posedge clock_in) begin
        // operation off holds the whole chain at phase 0
        if (!rst_b_in || !run) begin
            tick_ff <= 8'h00;
            frm_cnt_ff <= 4'h0;
            phase_ff <= 2'h0;
            invert_ff <= 1'b0;
            frame_pulse_ff <= 1'b0;
        end else begin
            frame_pulse_ff <= 1'b0;
            if (lcd_tick) begin
                tick_ff <= nxt_tick;
                frm_cnt_ff <= nxt_frm_cnt;
                // step phase after a full divider run
                if (tick_ff == phase_len - 8'h01 && frm_cnt_ff == frame_divider_field) begin
                    if (phase_ff >= last_phase) begin
                        phase_ff <= 2'h0;
                        invert_ff <= ~invert_ff;
                        frame_pulse_ff <= 1'b1;
                    end else begin
                        phase_ff <= phase_ff + 2'h1;
                    end
                end
            end
        end
    end

    // register map on the plain port:
    //   0x00..0x10 display memory, eight bits each
    //   0x11       control: contrast [4:0], ground [5],
    //              duty [7:6], clock select [8], divider [12:9]
    //   0x12       config: enable [0], operation [1],
    //              pin group function [7:4]
    //   0x13       status, read only
    // writes above 0x12 are dropped without error
    // data bits above a register's width are ignored
    // register writes; every byte stays plain storage
    always @(posedge clock_in) begin
        if (!rst_b_in) begin
            ctrl_ff <= `CTRL_RESET;
            cfg_ff <= `CFG_RESET;
            for (i = 0; i < 17; i = i + 1) begin
                mem_ff[i] <= 8'h00;
            end
        end else if (wr_in) begin
            if (addr_in <= `ADDR_MEM_LAST) begin
                mem_ff[addr_in] <= wdata_in[7:0];
            end else if (addr_in == `ADDR_CTRL) begin
                // only the low 13 bits exist
                ctrl_ff <= wdata_in[12:0];
            end else if (addr_in == `ADDR_CFG) begin
                // low byte only
                cfg_ff <= wdata_in[7:0];
            end
        end
    end

    // read data one cycle after strobe, zero otherwise
    // status gives software a live view of the phase counter;
    // it is a snapshot and may be stale by the time it is used
    always @(posedge clock_in) begin
        if (!rst_b_in) begin
            rdata_out <= 16'h0000;
        end else if (rd_in) begin
            if (addr_in <= `ADDR_MEM_LAST) begin
                rdata_out <= {8'h00, mem_ff[addr_in]};
            end else if (addr_in == `ADDR_CTRL) begin
                rdata_out <= {3'h0, ctrl_ff};
            end else if (addr_in == `ADDR_CFG) begin
                rdata_out <= {8'h00, cfg_ff};
            end else if (addr_in == `ADDR_STATUS) begin
                // live waveform state
                rdata_out <= {11'h000, lcd_tick, invert_ff, run,
                              phase_ff};
            end else begin
                rdata_out <= 16'h0000;
            end
        end else begin
            rdata_out <= 16'h0000;
        end
    end

    // memory map by duty, large package:
    //   static  byte s/8, bit s%8, common 0 only
    //   half    byte s/4, bit pair 2*(s%4), low bit common 0
    //   third   byte s/2, nibble s%2, bits 0..2 per common,
    //           top bit of each nibble never shown
    //   quarter byte s/2, nibble s%2, bit per common;
    //           the last byte shows its low nibble only
    // bits no mode shows are plain storage for software
    // the map is pure wiring from memory, so a write shows up
    // on the pins at the next cycle with no extra copy
    // memory bit for segment s at common c
    function seg_bit;
        input [5:0] s;
        input [1:0] c;
        input [1:0] d;
        reg   [7:0] b;
        begin
            b = 8'h00;
            seg_bit = 1'b0;
            case (d)
                `DUTY_STATIC: begin
                    b = mem_ff[s[5:3]];
                    seg_bit = b[s[2:0]];
                end
                // half duty, four segments per byte
                `DUTY_HALF: begin
                    b = mem_ff[s[5:2]];
                    seg_bit = b[{s[1:0], c[0]}];
                end
                // two segments per byte, bits 3/7 unused
                `DUTY_THIRD: begin
                    b = mem_ff[s[5:1]];
                    seg_bit = (c == 2'h3) ? 1'b0 : b[{s[0], c}];
                end
                // low nibble even, high nibble odd
                default: begin
                    b = mem_ff[s[5:1]];
                    // last byte: high nibble is storage only
                    seg_bit = (s[5:1] == 5'h10 && s[0]) ? 1'b0 :
                              b[{s[0], c}];
                end
            endcase
        end
    endfunction

    // both pin kinds drive only while running and enabled
    assign pins_on = run & cfg_ff[`CFG_DPE_BIT];

    // polarity: the selected common sits at ~invert and the
    // others at invert; a lit segment takes the level opposite
    // its selected common, an unlit one the same level, and
    // invert flips every frame so the glass sees no dc on average
    // segment pin levels and enables, one slice per pin
    generate
        for (g = 0; g < SEG_COUNT; g = g + 1) begin : seg_pin
            // which memory bit this pin shows is fixed by its index
            localparam [5:0] SEG_IDX = g;
            // four pin groups by index: nine pins in groups 0 to 2, seven in group 3
            localparam integer GRP = (g / 9) & 3;
            // bit one makes segment opposite backplane
            assign nxt_seg_level[g] =
                seg_bit(SEG_IDX, phase_ff, duty) ^ ~invert_ff;
            // pin group enabled by function bits
            assign nxt_seg_enable[g] =
                pins_on & cfg_ff[`CFG_PCF_LSB + GRP];
        end
    endgenerate

    // common pin levels and enables, one slice per common
    generate
        for (k = 0; k < 4; k = k + 1) begin : com_pin
            localparam [1:0] COM_IDX = k;
            assign nxt_com_enable[k] = pins_on & (COM_IDX <= last_phase);
            // selected common swings opposite the rest
            assign nxt_com_level[k] =
                (COM_IDX == phase_ff) ? ~invert_ff : invert_ff;
        end
    endgenerate

    // drive outputs; continuous while enabled
    // registered so pins never glitch while phases step
    always @(posedge clock_in) begin
        // pins released and low in reset
        if (!rst_b_in) begin
            segment_output_out <= {SEG_COUNT{1'b0}};
            segment_enable_out <= {SEG_COUNT{1'b0}};
            backplane_output_out <= 4'h0;
            backplane_enable_out <= 4'h0;
        end else begin
            // all four vectors update together
            segment_output_out <= nxt_seg_level;
            segment_enable_out <= nxt_seg_enable;
            backplane_output_out <= nxt_com_level;
            backplane_enable_out <= nxt_com_enable;
        end
    end
endmodule

// file: tb/lcd_drv_chk.sv
`timescale 1ns/10ps
`include "lcd_drv_defs.vh"
// port-level checks on bus, contrast outputs and frame timing
module lcd_drv_chk (
    input logic        clock_in,
    input logic        rst_b_in,
    input logic        stop_mode_in,
    input logic [4:0]  addr_in,
    input logic [15:0] wdata_in,
    input logic        wr_in,
    input logic        rd_in,
    input logic [15:0] rdata_out,
    input logic [3:0]  backplane_enable_out,
    input logic [4:0]  contrast_resistor_out,
    input logic        resistor_ground_out,
    input logic        frame_start_out
);
    logic [1:0] duty_ff, duty_d_ff, duty_dd_ff; // shadow duty, delayed
    logic       hf_sel_ff;                      // shadow clock select
    wire        ctl_wr = wr_in && addr_in == `ADDR_CTRL;
    wire  [3:0] com_mask = 4'hf >> (2'h3 - duty_dd_ff);
    // shadow of control writes; delay covers output lag
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            {hf_sel_ff, duty_ff, duty_d_ff, duty_dd_ff} <= 7'h00;
        end else begin
            if (ctl_wr) begin
                {hf_sel_ff, duty_ff} <= wdata_in[8:6];
            end
            duty_d_ff  <= duty_ff;
            duty_dd_ff <= duty_d_ff;
        end
    end
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);
    property p_rd_idle; !rd_in |=> rdata_out == 16'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_rd_unmap;
        rd_in && addr_in > `ADDR_STATUS |=> rdata_out == 16'h0;
    endproperty
    a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped read");
    property p_gnd; ctl_wr |=> resistor_ground_out == $past(wdata_in[5]);
    endproperty
    a_gnd: assert property (p_gnd) else $error("ground bit");
    property p_contrast;
        ctl_wr |=> contrast_resistor_out == $past(wdata_in[4:0]);
    endproperty
    a_contrast: assert property (p_contrast) else $error("contrast");
    property p_hold;
        !ctl_wr |=> $stable(resistor_ground_out)
            && $stable(contrast_resistor_out);
    endproperty
    a_hold: assert property (p_hold) else $error("contrast moved");
    property p_fs; frame_start_out |=> !frame_start_out [*8]; endproperty
    a_fs: assert property (p_fs) else $error("frame pulse");
    property p_com;
        duty_ff == duty_dd_ff && duty_d_ff == duty_ff
            |-> (backplane_enable_out & ~com_mask) == 4'h0;
    endproperty
    a_com: assert property (p_com) else $error("extra common");
    property p_stop;
        hf_sel_ff && stop_mode_in && $past(stop_mode_in, 2)
            |-> !frame_start_out;
    endproperty
    a_stop: assert property (p_stop) else $error("frame in stop");
    c_frame: cover property (frame_start_out);
    c_stop: cover property (hf_sel_ff && stop_mode_in);
    c_ctl: cover property (ctl_wr);
endmodule

// file: tb/lcd_panel.sv
`timescale 1ns/10ps
// passive glass: latches which common/segment crossings lit last frame
module lcd_panel (
    input  logic         clock_in,
    input  logic         rst_b_in,
    input  logic         frame_start_in,
    input  logic [33:0]  seg_in,
    input  logic [33:0]  seg_en_in,
    input  logic [3:0]   com_in,
    input  logic [3:0]   com_en_in,
    output logic [135:0] lit_out
);
    logic         inv_ff, fs_d_ff; // polarity guess, guard
    logic [3:0]   com_d_ff;        // last common levels
    logic [135:0] acc_ff;          // lit seen this frame
    // skips cycles near a flip, as polarity timing is not known exactly
    always_ff @(posedge clock_in) begin
        if (!rst_b_in) begin
            {inv_ff, fs_d_ff, com_d_ff} <= 6'h00;
            acc_ff  <= '0;
            lit_out <= '0;
        end else begin
            fs_d_ff  <= frame_start_in;
            com_d_ff <= com_in;
            if (frame_start_in) begin
                inv_ff  <= ~inv_ff;
                lit_out <= acc_ff;
                acc_ff  <= '0;
            end else if (!fs_d_ff && com_in == com_d_ff) begin
                for (int c = 0; c < 4; c++) begin
                    if (com_en_in[c] && com_in[c] != inv_ff) begin
                        acc_ff[c*34 +: 34] <= acc_ff[c*34 +: 34]
                            | (seg_en_in & (seg_in ^ {34{com_in[c]}}));
                    end
                end
            end
        end
    end
endmodule

// file: tb/segment_lcd_mux_driver_test.sv
`timescale 1ns/10ps
`include "lcd_drv_defs.vh"
module segment_lcd_mux_driver_test;
    logic clock_in = 0, rst_b_in = 0, tick = 0, hf = 1, stop = 0, warm = 1;
    logic        wr = 0, rd = 0;
    logic [4:0]  addr = 5'h00;
    logic [15:0] wdata = 16'h0000;
    wire  [15:0] rdata;
    wire  [33:0] seg, seg_en;
    wire  [3:0]  com, com_en;
    wire         fs;
    wire [135:0] lit;
    int          err_total = 0, checks = 0;
    logic [7:0]  mem [17];   // shadow of display memory
    segment_lcd_mux_driver i_segment_lcd_mux_driver (.clock_in(clock_in),
        .rst_b_in(rst_b_in), .clk_32k_tick_in(tick), .hf_clk_tick_in(hf),
        .stop_mode_in(stop), .hf_warm_in(warm), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
        .segment_output_out(seg), .segment_enable_out(seg_en),
        .backplane_output_out(com), .backplane_enable_out(com_en),
        .contrast_resistor_out(), .resistor_ground_out(),
        .frame_start_out(fs));
    lcd_panel i_lcd_panel (.clock_in(clock_in), .rst_b_in(rst_b_in),
        .frame_start_in(fs), .seg_in(seg), .seg_en_in(seg_en), .com_in(com),
        .com_en_in(com_en), .lit_out(lit));
    initial forever #25 clock_in = ~clock_in;
    // slow tick every other cycle keeps frames short
    always @(posedge clock_in) tick <= ~tick;
    task check(input string n, input logic [35:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task wr_reg(input [4:0] a, input [15:0] d);
        @(posedge clock_in); wr <= 1; addr <= a; wdata <= d;
        @(posedge clock_in); wr <= 0;
    endtask
    task rd_chk(input [4:0] a, input [15:0] e, input string n);
        @(posedge clock_in); rd <= 1; addr <= a;
        @(posedge clock_in); rd <= 0;
        @(negedge clock_in); check(n, rdata, e);
    endtask
    // cycles to the next frame pulse, bounded
    task wait_fs(output int n);
        n = 0;
        do begin @(posedge clock_in); n++; end while (!fs && n < 20000);
    endtask
    // expected lit crossings from the memory map of each duty
    function logic [33:0] exp_seg(input int d, input int c);
        logic [33:0] r;
        for (int s = 0; s < 34; s++) begin
            case (d)
                0: r[s] = c == 0 && mem[s/8][s%8];
                1: r[s] = c < 2 && mem[s/4][2*(s%4)+c];
                default: r[s] = c <= d && !(d == 3 && s == 33)
                                && mem[s/2][4*(s%2)+c];
            endcase
        end
        return r;
    endfunction
    initial begin
        int n, p;
        repeat (8) @(posedge clock_in);
        rst_b_in <= 1;
        rd_chk(`ADDR_CTRL, 16'h0000, "ctrl reset");
        rd_chk(`ADDR_CFG, 16'h0000, "cfg reset");
        for (int i = 0; i < 17; i++) begin
            mem[i] = 8'h5a ^ (8'h13 * i[7:0]);
            wr_reg(i[4:0], {8'h00, mem[i]});
        end
        for (int i = 0; i < 17; i++)
            rd_chk(i[4:0], {8'h00, mem[i]}, "mem");
        rd_chk(5'h1f, 16'h0000, "unmapped");
        wr_reg(`ADDR_CFG, 16'h00f3);
        for (int d = 0; d < 4; d++) begin
            wr_reg(`ADDR_CTRL, {7'h01, 1'b0, d[1:0], 6'h35});
            rd_chk(`ADDR_CTRL, {7'h01, 1'b0, d[1:0], 6'h35}, "ctrl");
            wait_fs(n); wait_fs(p); wait_fs(n);
            check("frame", p, (d == 2 ? 96 : 64) * 4);
            for (int c = 0; c < 4; c++)
                check("lit", lit[c*34 +: 34], exp_seg(d, c));
            $display("duty %0d done", d);
        end
        wr_reg(`ADDR_CTRL, 16'h0120);
        wait_fs(n); wait_fs(p);
        check("fast frame", p, 64 * 128);
        stop <= 1; warm <= 0; n = 0;
        repeat (9000) begin @(posedge clock_in); n += fs; end
        check("stop frames", n, 0);
        stop <= 0; warm <= 1;
        wait_fs(n);
        check("resume", n < 8300, 1);
        stop <= 1;
        wr_reg(`ADDR_CTRL, 16'h0020);
        wait_fs(n); wait_fs(p);
        check("slow in stop", p, 128);
        $display("clock tests done");
        final_report;
    end
    initial begin
        repeat (100000) @(posedge clock_in);
        err_total++;
        final_report;
    end
endmodule
bind segment_lcd_mux_driver lcd_drv_chk i_lcd_drv_chk (.clock_in, .rst_b_in,
    .stop_mode_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .backplane_enable_out, .contrast_resistor_out, .resistor_ground_out,
    .frame_start_out);
